/* verilog/soc_params.svh */
// Constants of the sensor output stage control block
`ifndef SOC_PARAMS_SVH
`define SOC_PARAMS_SVH
`define SOC_VAL_W 15
`define SOC_DAC_W 11
`define SOC_PWM_MAX_W 12
`define SOC_PWM_MIN_RES 4'h9
`define SOC_PWM_MAX_RES 4'hC
`define SOC_CLK_MHZ 100
`define SOC_START_WIN_MS 20
`define SOC_START_WIN_CYC (`SOC_START_WIN_MS * 1000 * `SOC_CLK_MHZ)
`define SOC_WDOG_CYC 32'd1000000
`define SOC_ERR_CODE 16'hFFFF
`define SOC_DAC_MAX 11'h7FF
`define SOC_DAC_MIN 11'h000
`define SOC_DLY_W 16
`define SOC_DIV_W 16
`endif

/* verilog/soc_pkg.sv */
// Types of the sensor output stage control block
package soc_pkg;
  typedef enum logic [1:0] {SOC_SRC_BRIDGE, SOC_SRC_TEMP1, SOC_SRC_TEMP2,
    SOC_SRC_NONE} soc_src_t;
  typedef enum logic {SOC_OUT_ANALOG, SOC_OUT_PWM} soc_out_mode_t;
  typedef enum logic {SOC_SIF_I2C, SOC_SIF_SPI} soc_sif_t;
  typedef enum {SOC_WIN, SOC_ONEWIRE, SOC_RUN} soc_mode_t;
  // Alarm channel settings
  typedef struct packed {
    logic enable;
    logic window;
    logic active_low;
    logic [14:0] thresh;
    logic [14:0] thresh_hi;
    logic [14:0] hyst;
    logic [15:0] on_delay;
    logic [15:0] off_delay;
  } soc_alarm_cfg_t;
  // Nonvolatile configuration
  typedef struct packed {
    logic start_win_en;
    soc_sif_t sif;
    soc_out_mode_t out_mode;
    logic pwm_b_on_io_a;
    logic alarm_a_en_pin;
    logic alarm_b_en_pin;
    logic diag_high;
    logic [3:0] pwm_res;
    logic [15:0] pwm_div;
  } soc_cfg_t;
  // Fault sources
  typedef struct packed {
    logic bridge_pos_oor;
    logic bridge_neg_oor;
    logic common_mode;
    logic mem_corrupt;
  } soc_fault_t;
  // Per alarm channel state
  typedef struct packed {
    logic raw;
    logic out;
    logic [15:0] cnt;
  } soc_alarm_st_t;
  // Whole state of the block
  typedef struct packed {
    soc_mode_t mode;
    logic [31:0] win_cnt;
    logic [31:0] wdog_cnt;
    logic diag;
    logic [15:0] div_cnt;
    logic [11:0] pwm_cnt;
    soc_alarm_st_t [1:0] alm;
    logic [10:0] dac;
    logic out_pwm;
    logic out_oe;
    logic io_a;
    logic io_a_oe;
    logic io_b;
    logic io_b_oe;
    logic [15:0] sif_data;
    logic spi_sel;
    logic [1:0] ss_sync;
    logic [1:0] req_sync;
    logic ow_mode;
    logic is_spi;
  } soc_state_t;
endpackage : soc_pkg

/* verilog/soc_output_stage.sv */
// Output stage control of a bridge-sensor conditioner
`timescale 1ns/100ps
`include "soc_params.svh"
// How it works
// - Three 15-bit result registers: bridge, temperature one, temperature two.
// - Each result is routed to the primary slot or the shared pin slot.
// - Voltage module gets an 11-bit code from its assigned result.
// - PWM modules emit a continuous pulse train following the value.
// - Period from resolution and divider; resolution 9 to 12 bits.
// - In SPI mode transfers take shared pin A from the first PWM.
// - Alarm channel A goes to shared pin A, channel B to pin B.
// - Each alarm has threshold, hysteresis, polarity, on and off delays.
// - Window mode flags the value lying between two limits.
// - In SPI mode pin B is slave select, pin A serial data out.
// - After reset the link stays one-wire for a 20 ms window.
// - A valid request inside the window keeps one-wire mode.
// - One-wire mode ends only on an exit command or a new reset.
// - No request by window end selects I2C or SPI from configuration.
// - At window end the primary pin becomes analog or PWM output.
// - A configuration bit disables the window, going straight to run.
// - Any error enters diagnostics, analog output forced to max or min.
// - In diagnostics the serial output registers carry an error code.
// - Watchdog raises an error when controller or measurement loop stall.
// - Either bridge input comparator out of range is a broken wire error.
// - A common-mode violation is an aging error.
// - Memory or register corruption reports an error.
// - Alarms compare only the bridge result.
// - In SPI mode pin B cannot carry alarm channel B.
module soc_output_stage import soc_pkg::*; #(
  parameter int unsigned START_WIN_CYC = `SOC_START_WIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Results and routing
  input wire logic [`SOC_VAL_W-1:0] val_bridge,
  input wire logic [`SOC_VAL_W-1:0] val_temp1,
  input wire logic [`SOC_VAL_W-1:0] val_temp2,
  input wire soc_src_t src_primary,
  input wire soc_src_t src_io_a,
  input wire soc_cfg_t cfg,
  input wire soc_alarm_cfg_t alarm_cfg_a,
  input wire soc_alarm_cfg_t alarm_cfg_b,
  // Serial interface side
  input wire logic onewire_req,
  input wire logic onewire_exit,
  input wire logic spi_busy,
  input wire logic serial_data_out,
  input wire logic [15:0] sif_result,
  input wire logic shared_io_pin_b_in,
  // Supervision
  input wire logic calibration_microcontroller_alive,
  input wire logic meas_loop_alive,
  input wire soc_fault_t fault,
  // Outputs
  output logic [`SOC_DAC_W-1:0] dac_code,
  output logic out_pin,
  output logic out_pin_oe,
  output logic shared_io_pin_a,
  output logic shared_io_pin_a_oe,
  output logic shared_io_pin_b,
  output logic shared_io_pin_b_oe,
  output logic spi_select,
  output logic onewire_mode,
  output logic sif_is_spi,
  output logic [15:0] sif_data,
  output logic diag_mode,
  output logic alarm_channel_a,
  output logic alarm_channel_b
);

  localparam logic [31:0] WIN_CYC = START_WIN_CYC;
  soc_state_t s_q, s_d;
  logic [`SOC_VAL_W-1:0] v_pri, v_ioa;
  logic [11:0] duty_pri, duty_ioa, pwm_top;
  logic tick, pwm_channel_a, pwm_channel_b, any_err, spi_on;
  logic [1:0] alarm_hit;
  soc_alarm_cfg_t [1:0] acfg;

  ////////////////////////////////////////////////////////////////////////
  // Routing of result registers to slots
  function automatic logic [`SOC_VAL_W-1:0] pick(input soc_src_t sel,
      input logic [`SOC_VAL_W-1:0] b, input logic [`SOC_VAL_W-1:0] t1,
      input logic [`SOC_VAL_W-1:0] t2);
    case (sel)
      SOC_SRC_BRIDGE: pick = b;
      SOC_SRC_TEMP1: pick = t1;
      SOC_SRC_TEMP2: pick = t2;
      default: pick = '0;
    endcase
  endfunction : pick

  assign v_pri = pick(src_primary, val_bridge, val_temp1, val_temp2);
  assign v_ioa = pick(src_io_a, val_bridge, val_temp1, val_temp2);

  // Duty from top bits of value at selected resolution
  function automatic logic [11:0] duty(input logic [`SOC_VAL_W-1:0] v,
      input logic [3:0] res);
    logic [11:0] top;
    top = v[`SOC_VAL_W-1 -: 12];
    duty = top >> (4'hC - res);
  endfunction : duty

  always_comb begin
    pwm_top = (12'h001 << cfg.pwm_res) - 12'h001;
  end
  assign duty_pri = duty(v_pri, cfg.pwm_res);
  assign duty_ioa = duty(v_ioa, cfg.pwm_res);
  assign tick = (s_q.div_cnt == cfg.pwm_div);
  // Primary PWM is the second channel, shared pin PWM the first
  assign pwm_channel_b = (s_q.pwm_cnt < duty_pri);
  assign pwm_channel_a = (s_q.pwm_cnt < duty_ioa);
  assign any_err = |fault | (s_q.wdog_cnt >= `SOC_WDOG_CYC);
  assign spi_on = (s_q.mode == SOC_RUN) && (cfg.sif == SOC_SIF_SPI);
  assign acfg[0] = alarm_cfg_a;
  assign acfg[1] = alarm_cfg_b;

  ////////////////////////////////////////////////////////////////////////
  // Alarm comparators, bridge value only
  for (genvar i = 0; i < 2; i++) begin : g_alm
    logic [15:0] lo, hi;
    always_comb begin
      lo = {1'b0, acfg[i].thresh};
      hi = {1'b0, acfg[i].thresh_hi};
      if (acfg[i].window) begin
        if (s_q.alm[i].raw)
          alarm_hit[i] = ({1'b0, val_bridge} + {1'b0, acfg[i].hyst} >= lo)
            && ({1'b0, val_bridge} <= hi + {1'b0, acfg[i].hyst});
        else
          alarm_hit[i] = (val_bridge >= acfg[i].thresh)
            && (val_bridge <= acfg[i].thresh_hi);
      end else if (s_q.alm[i].raw) begin
        // Hysteresis below threshold to release
        alarm_hit[i] = ({1'b0, val_bridge} + {1'b0, acfg[i].hyst} >= lo);
      end else begin
        alarm_hit[i] = (val_bridge >= acfg[i].thresh);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ss_sync = {s_q.ss_sync[0], shared_io_pin_b_in};
    s_d.req_sync = {s_q.req_sync[0], onewire_req};
    // Interface start window
    case (s_q.mode)
      SOC_WIN: begin
        if (!cfg.start_win_en) begin
          s_d.mode = SOC_RUN;
        end else if (s_q.req_sync[1]) begin
          s_d.mode = SOC_ONEWIRE;
        end else if (s_q.win_cnt >= WIN_CYC - 32'd1) begin
          s_d.mode = SOC_RUN;
        end else begin
          s_d.win_cnt = s_q.win_cnt + 32'd1;
        end
      end
      SOC_ONEWIRE: begin
        if (onewire_exit)
          s_d.mode = SOC_RUN;
      end
      SOC_RUN: s_d.mode = SOC_RUN;
      default: s_d.mode = SOC_WIN;
    endcase
    // Watchdog
    if (calibration_microcontroller_alive && meas_loop_alive)
      s_d.wdog_cnt = '0;
    else if (s_q.wdog_cnt < `SOC_WDOG_CYC)
      s_d.wdog_cnt = s_q.wdog_cnt + 32'd1;
    if (any_err)
      s_d.diag = 1'b1;
    // PWM counter and divider
    if (tick) begin
      s_d.div_cnt = '0;
      s_d.pwm_cnt = (s_q.pwm_cnt >= pwm_top) ? 12'h000
        : s_q.pwm_cnt + 12'h001;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 16'h0001;
    end
    // Alarm delays
    for (int i = 0; i < 2; i++) begin
      s_d.alm[i].raw = alarm_hit[i];
      if (alarm_hit[i] == s_q.alm[i].out) begin
        s_d.alm[i].cnt = '0;
      end else if (s_q.alm[i].cnt >= (alarm_hit[i] ? acfg[i].on_delay
          : acfg[i].off_delay)) begin
        s_d.alm[i].out = alarm_hit[i];
        s_d.alm[i].cnt = '0;
      end else begin
        s_d.alm[i].cnt = s_q.alm[i].cnt + 16'h0001;
      end
    end
    // Analog code
    if (s_q.diag)
      s_d.dac = cfg.diag_high ? `SOC_DAC_MAX : `SOC_DAC_MIN;
    else
      s_d.dac = v_pri[`SOC_VAL_W-1 -: `SOC_DAC_W];
    s_d.sif_data = s_q.diag ? `SOC_ERR_CODE : sif_result;
    // Primary pin
    s_d.out_pwm = pwm_channel_b;
    s_d.out_oe = (s_q.mode == SOC_RUN) && (cfg.out_mode == SOC_OUT_PWM);
    // Shared pin A
    s_d.spi_sel = spi_on && !s_q.ss_sync[1];
    if (spi_on && spi_busy) begin
      s_d.io_a = serial_data_out;
      s_d.io_a_oe = 1'b1;
    end else if (cfg.pwm_b_on_io_a) begin
      s_d.io_a = pwm_channel_a;
      s_d.io_a_oe = 1'b1;
    end else begin
      s_d.io_a = s_q.alm[0].out ^ acfg[0].active_low;
      s_d.io_a_oe = cfg.alarm_a_en_pin && acfg[0].enable;
    end
    // Shared pin B
    s_d.io_b = s_q.alm[1].out ^ acfg[1].active_low;
    s_d.io_b_oe = cfg.alarm_b_en_pin && acfg[1].enable
      && !(cfg.sif == SOC_SIF_SPI);
    // Registered copies of the mode outputs, so pins come from flops
    s_d.ow_mode = (s_d.mode != SOC_RUN);
    s_d.is_spi = (s_d.mode == SOC_RUN) && (cfg.sif == SOC_SIF_SPI);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      // Link sits in the start window while reset holds
      s_q.ow_mode <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dac_code = s_q.dac;
  assign out_pin = s_q.out_pwm;
  assign out_pin_oe = s_q.out_oe;
  assign shared_io_pin_a = s_q.io_a;
  assign shared_io_pin_a_oe = s_q.io_a_oe;
  assign shared_io_pin_b = s_q.io_b;
  assign shared_io_pin_b_oe = s_q.io_b_oe;
  assign spi_select = s_q.spi_sel;
  assign onewire_mode = s_q.ow_mode;
  assign sif_is_spi = s_q.is_spi;
  assign sif_data = s_q.sif_data;
  assign diag_mode = s_q.diag;
  assign alarm_channel_a = s_q.alm[0].out;
  assign alarm_channel_b = s_q.alm[1].out;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_err;
    |fault;
  endsequence
  a_diag_on_fault: assert property (s_err |=> diag_mode)
    else $error("fault did not enter diagnostics");
  a_diag_sticky: assert property (diag_mode |=> diag_mode)
    else $error("diagnostics left");
  a_diag_dac: assert property (diag_mode && cfg.diag_high |=>
      dac_code == `SOC_DAC_MAX)
    else $error("dac not at max in diagnostics");
  a_diag_code: assert property (diag_mode |=> sif_data == `SOC_ERR_CODE)
    else $error("error code missing");
  a_win_skip: assert property (s_q.mode == SOC_WIN && !cfg.start_win_en
      |=> !onewire_mode)
    else $error("window not skipped");
  a_onewire_hold: assert property (s_q.mode == SOC_ONEWIRE && !onewire_exit
      |=> onewire_mode)
    else $error("one-wire left without exit");
  a_win_early: assert property ($rose(nrst) |-> onewire_mode)
    else $error("not one-wire after reset");
  a_pinb_spi: assert property (cfg.sif == SOC_SIF_SPI |=>
      !shared_io_pin_b_oe)
    else $error("pin b driven in spi mode");
  a_sdo_route: assert property (spi_on && spi_busy |=> shared_io_pin_a_oe
      && shared_io_pin_a == $past(serial_data_out))
    else $error("data out not on pin a");
  a_pwm_wrap: assert property (tick && s_q.pwm_cnt >= pwm_top
      |=> s_q.pwm_cnt == 12'h000)
    else $error("pwm counter did not wrap");

  // Stalled heartbeat must end in diagnostics
  a_wdog_diag: assert property (s_q.wdog_cnt >= `SOC_WDOG_CYC
      |=> diag_mode)
    else $error("watchdog expiry did not enter diagnostics");

  // Request seen through the synchroniser inside the window
  sequence s_req_seen;
    s_q.mode == SOC_WIN && cfg.start_win_en && s_q.req_sync[1];
  endsequence
  a_req_keep: assert property (s_req_seen |=> onewire_mode
      && s_q.mode == SOC_ONEWIRE)
    else $error("request in window did not keep one-wire");

  // Window still open: link stays one-wire
  a_win_stay: assert property (s_q.mode == SOC_WIN && cfg.start_win_en
      && s_q.win_cnt < WIN_CYC - 32'd1 |=> onewire_mode)
    else $error("one-wire left inside the window");

  // Window ran out with no request: leave one-wire
  a_win_end: assert property (s_q.mode == SOC_WIN && cfg.start_win_en
      && !s_q.req_sync[1] && s_q.win_cnt >= WIN_CYC - 32'd1
      |=> !onewire_mode)
    else $error("window end did not switch interface");

  // Primary pin enabled as PWM output in run mode
  a_out_oe: assert property (s_q.mode == SOC_RUN
      && cfg.out_mode == SOC_OUT_PWM |=> out_pin_oe)
    else $error("primary pwm output not enabled");

  // Pin B carries alarm B outside SPI mode
  a_io_b_alarm: assert property (cfg.sif == SOC_SIF_I2C
      && cfg.alarm_b_en_pin && alarm_cfg_b.enable
      |=> shared_io_pin_b_oe)
    else $error("alarm b not driven on pin b");

  // Assertion delay holds the alarm off on the first hit
  a_alarm_delay: assert property (alarm_hit[0] && !s_q.alm[0].out
      && s_q.alm[0].cnt == 16'h0000 && alarm_cfg_a.on_delay != 16'h0000
      |=> !alarm_channel_a)
    else $error("alarm a set before its delay");

endmodule : soc_output_stage

/* test/soc_host_model.sv */
// Host side model: one-wire request and serial transfers
`timescale 1ns/100ps
module soc_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Commands from the bench
  input wire logic go_req,
  input wire logic go_xfer,
  // Lines towards the block
  output logic onewire_req,
  output logic spi_busy,
  output logic ss_n,
  output logic sdo
);
  logic [4:0] req_q;
  logic [4:0] xfer_q;
  // Request and transfer counters, data bit per half transfer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= 5'h00;
      xfer_q <= 5'h00;
      sdo <= 1'b0;
    end else begin
      req_q <= go_req ? 5'h04 : (|req_q ? req_q - 5'h01 : 5'h00);
      xfer_q <= go_xfer ? 5'h10 : (|xfer_q ? xfer_q - 5'h01 : 5'h00);
      // Outside transfers the data line keeps changing
      sdo <= |xfer_q ? (xfer_q > 5'h08) : ~sdo;
    end
  end
  // Request on the primary pin, select low while transferring
  assign onewire_req = |req_q;
  assign spi_busy = |xfer_q;
  assign ss_n = ~|xfer_q;
endmodule : soc_host_model

/* test/soc_output_stage_tb_top.sv */
// Self-checking testbench of the output stage control block
`timescale 1ns/100ps
`include "soc_params.svh"
module soc_output_stage_tb_top import soc_pkg::*;;
  localparam int WIN = 50;
  logic clk, nrst, onewire_req, onewire_exit, spi_busy, serial_data_out;
  logic shared_io_pin_b_in, go_req, go_xfer, ss_n;
  logic [14:0] val_bridge, val_temp1, val_temp2;
  logic [15:0] sif_result, sif_data;
  soc_src_t src_primary, src_io_a;
  soc_cfg_t cfg;
  soc_alarm_cfg_t alarm_cfg_a, alarm_cfg_b;
  soc_fault_t fault;
  logic [10:0] dac_code;
  logic out_pin, out_pin_oe, shared_io_pin_a, shared_io_pin_a_oe;
  logic shared_io_pin_b, shared_io_pin_b_oe, spi_select, onewire_mode;
  logic sif_is_spi, diag_mode, alarm_channel_a, alarm_channel_b;
  int n_mismatch, checked, hi, lo;
  ////////////////////////////////////////
  // Block and host
  soc_output_stage #(.START_WIN_CYC(WIN)) soc_output_stage_inst (
    .clk, .nrst, .val_bridge, .val_temp1, .val_temp2, .src_primary,
    .src_io_a, .cfg, .alarm_cfg_a, .alarm_cfg_b, .onewire_req,
    .onewire_exit, .spi_busy, .serial_data_out, .sif_result,
    .shared_io_pin_b_in, .calibration_microcontroller_alive(1'b1),
    .meas_loop_alive(1'b1), .fault, .dac_code, .out_pin, .out_pin_oe,
    .shared_io_pin_a, .shared_io_pin_a_oe, .shared_io_pin_b,
    .shared_io_pin_b_oe, .spi_select, .onewire_mode, .sif_is_spi,
    .sif_data, .diag_mode, .alarm_channel_a, .alarm_channel_b
  );
  soc_host_model soc_host_model_inst (
    .clk, .nrst, .go_req, .go_xfer, .onewire_req, .spi_busy, .ss_n,
    .sdo(serial_data_out)
  );
  // Pin B wire level from whoever drives it
  assign shared_io_pin_b_in = shared_io_pin_b_oe ? shared_io_pin_b : ss_n;
  ////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  ////////////////////////////////////////
  // Tasks
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic endt(string nm);
    $display("test %s ended, %0d mismatches", nm, n_mismatch);
  endtask : endt
  task automatic rst();
    nrst <= 1'b0;
    cyc(12);
    chk("onewire_mode", 1, onewire_mode);
    nrst <= 1'b1;
  endtask : rst
  task automatic run(input logic v, output int n);
    n = 0;
    while (out_pin === v && n < 9000) begin
      cyc(1);
      n++;
    end
  endtask : run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  // Test sequence
  initial begin
    nrst = 1'b0;
    {onewire_exit, go_req, go_xfer, fault} = '0;
    {val_bridge, val_temp1, val_temp2} = '0;
    {alarm_cfg_a, alarm_cfg_b, cfg} = '0;
    cfg.pwm_res = 4'h9;
    src_primary = SOC_SRC_BRIDGE;
    src_io_a = SOC_SRC_BRIDGE;
    sif_result = 16'h1234;
    n_mismatch = 0;
    checked = 0;
    // Request inside the start window, then exit command
    cfg.start_win_en <= 1'b1;
    cfg.sif <= SOC_SIF_SPI;
    rst();
    cyc(5);
    go_req <= 1'b1;
    cyc(1);
    go_req <= 1'b0;
    cyc(WIN + 10);
    chk("onewire_mode", 1, onewire_mode);
    onewire_exit <= 1'b1;
    cyc(1);
    onewire_exit <= 1'b0;
    cyc(3);
    chk("onewire_mode", 0, onewire_mode);
    chk("sif_is_spi", 1, sif_is_spi);
    endt("window request");
    // No request: window runs out, analog output routing
    rst();
    cyc(WIN - 10);
    chk("onewire_mode", 1, onewire_mode);
    cyc(20);
    chk("onewire_mode", 0, onewire_mode);
    val_bridge <= 15'h5A5B;
    val_temp1 <= 15'h3C3D;
    cyc(4);
    chk("dac_code", 15'h5A5B >> 4, dac_code);
    src_primary <= SOC_SRC_TEMP1;
    cyc(4);
    chk("dac_code", 15'h3C3D >> 4, dac_code);
    endt("window expiry");
    // Window disabled, two-wire bus selected
    cfg.start_win_en <= 1'b0;
    cfg.sif <= SOC_SIF_I2C;
    rst();
    cyc(4);
    chk("onewire_mode", 0, onewire_mode);
    chk("sif_is_spi", 0, sif_is_spi);
    endt("window disabled");
    // Alarms: threshold with delay, window mode, pin routing
    cfg.alarm_a_en_pin <= 1'b1;
    cfg.alarm_b_en_pin <= 1'b1;
    alarm_cfg_a.enable <= 1'b1;
    alarm_cfg_a.thresh <= 15'h1000;
    alarm_cfg_a.on_delay <= 16'h0004;
    alarm_cfg_b.enable <= 1'b1;
    alarm_cfg_b.window <= 1'b1;
    alarm_cfg_b.thresh <= 15'h1000;
    alarm_cfg_b.thresh_hi <= 15'h3000;
    val_bridge <= 15'h0800;
    val_temp1 <= 15'h7000;
    cyc(10);
    chk("alarm_a", 0, alarm_channel_a);
    chk("alarm_b", 0, alarm_channel_b);
    val_bridge <= 15'h2000;
    cyc(2);
    chk("alarm_a", 0, alarm_channel_a);
    cyc(10);
    chk("alarm_a", 1, alarm_channel_a);
    chk("alarm_b", 1, alarm_channel_b);
    chk("pin_a", 1, shared_io_pin_a);
    chk("pin_b", 1, shared_io_pin_b);
    val_bridge <= 15'h4000;
    cyc(8);
    chk("alarm_b", 0, alarm_channel_b);
    endt("alarms");
    // Serial transfer takes pin A, pin B is select
    cfg.sif <= SOC_SIF_SPI;
    cfg.pwm_b_on_io_a <= 1'b1;
    rst();
    cyc(4);
    chk("pin_b_oe", 0, shared_io_pin_b_oe);
    go_xfer <= 1'b1;
    cyc(1);
    go_xfer <= 1'b0;
    cyc(6);
    chk("spi_select", 1, spi_select);
    chk("pin_a", 1, shared_io_pin_a);
    cyc(8);
    chk("pin_a", 0, shared_io_pin_a);
    endt("serial transfer");
    // PWM duty at every resolution
    cfg.out_mode <= SOC_OUT_PWM;
    src_primary <= SOC_SRC_BRIDGE;
    val_bridge <= 15'h2A5F;
    for (int r = 9; r <= 12; r++) begin
      cfg.pwm_res <= 4'(r);
      rst();
      run(1'b1, hi);
      run(1'b0, hi);
      run(1'b1, hi);
      run(1'b0, lo);
      chk("out_pin_oe", 1, out_pin_oe);
      lo = (12'h54B >> (12 - r)) * (hi + lo);
      chk("pwm_duty", hi << r, lo);
    end
    endt("pwm");
    // Each fault source forces the diagnostic state
    cfg.out_mode <= SOC_OUT_ANALOG;
    for (int i = 0; i < 4; i++) begin
      cfg.diag_high <= i[0];
      rst();
      cyc(3);
      chk("sif_data", 16'h1234, sif_data);
      fault <= soc_fault_t'(4'h1 << i);
      cyc(4);
      fault <= soc_fault_t'(4'h0);
      chk("diag_mode", 1, diag_mode);
      chk("dac_code", i[0] ? 11'h7FF : 11'h000, dac_code);
      chk("sif_data", 16'hFFFF, sif_data);
      cyc(5);
      chk("diag_mode", 1, diag_mode);
    end
    endt("diagnostics");
    conclude();
  end
endmodule : soc_output_stage_tb_top
